/* logic/cqm_pkg.sv */
// constants, register layouts and state types of the clock input qualification monitor
`default_nettype none
package cqm_pkg;

	localparam int NREF = 4;

	// register address fields: byte offsets, ref block numbers and register word indexes
	localparam logic [7:0] OFF_CTRL = 8'h00;
	localparam logic [7:0] OFF_STATUS = 8'h04;
	localparam logic [3:0] REF_FIRST = 4'h1;
	localparam logic [3:0] REF_LAST = 4'h4;
	localparam logic [1:0] REG_CFG = 2'h0;
	localparam logic [1:0] REG_WIN = 2'h1;
	localparam logic [1:0] REG_PPM = 2'h2;
	localparam logic [1:0] REG_VAL = 2'h3;
	localparam logic [23:0] ADDR_HIGH_ZERO = 24'h000000;
	localparam logic [1:0] ADDR_ALIGNED = 2'h0;

	// threshold and edge encodings
	localparam logic [1:0] THR_LOW = 2'h0;
	localparam logic [1:0] THR_MID = 2'h1;
	localparam logic [1:0] EDGE_RISE = 2'h0;
	localparam logic [1:0] EDGE_FALL = 2'h1;

	// zero-ppm ticks per gate before averaging
	localparam logic [23:0] GATE_TICKS = 24'h000400;

	typedef struct packed {
		logic [20:0] rsvd;
		logic [1:0] loop1_sel;
		logic [1:0] loop0_sel;
		logic ppm_src_tcxo;
		logic [1:0] tcxo_edge_sel;
		logic [1:0] xo_thr_sel;
		logic tcxo_bypass;
		logic xo_bypass;
	} cqm_ctrl_s;

	typedef struct packed {
		logic [18:0] rsvd;
		logic [2:0] avg;
		logic [1:0] edge_sel;
		logic [1:0] amp_thr;
		logic diff_mode;
		logic val_en;
		logic ppm_en;
		logic early_en;
		logic late_en;
		logic amp_en;
	} cqm_ref_cfg_s;

	typedef struct packed {
		logic [15:0] nominal;
		logic [7:0] late_margin;
		logic [7:0] early_margin;
	} cqm_win_cfg_s;

	typedef struct packed {
		logic [15:0] expected;
		logic [7:0] valid_thr;
		logic [7:0] invalid_thr;
	} cqm_ppm_cfg_s;

	typedef struct packed {
		logic [11:0] rsvd;
		logic [19:0] val_time;
	} cqm_val_cfg_s;

	typedef struct packed {
		logic win;
		logic ppm;
		logic amp;
	} cqm_loop_flags_s;

	typedef struct packed {
		logic [15:0] rsvd;
		cqm_loop_flags_s loop1;
		cqm_loop_flags_s loop0;
		logic [3:0] qualified;
		logic tcxo_valid;
		logic xo_valid;
		logic tcxo_freq;
		logic tcxo_amp;
		logic xo_freq;
		logic xo_amp;
	} cqm_status_s;

	typedef struct packed {
		logic clk_prev;
		logic [16:0] win_cnt;
		logic late_flag;
		logic early_flag;
		logic win_flag;
		logic amp_flag;
		logic ppm_flag;
		logic qualified;
		logic [19:0] val_cnt;
		logic [23:0] gate_cnt;
		logic [23:0] edge_cnt;
	} cqm_ref_st_s;

	typedef struct packed {
		logic dp_write;
		logic [7:0] dp_addr;
		logic [31:0] hrdata;
		logic hreadyout;
		logic hresp;
		cqm_ctrl_s ctrl;
		cqm_ref_cfg_s [NREF-1:0] cfg;
		cqm_win_cfg_s [NREF-1:0] win;
		cqm_ppm_cfg_s [NREF-1:0] ppm;
		cqm_val_cfg_s [NREF-1:0] val;
		cqm_ref_st_s [NREF-1:0] st;
		logic xo_amp_flag;
		logic xo_freq_flag;
		logic xo_loss;
		logic xo_valid;
		logic tcxo_amp_flag;
		logic tcxo_freq_flag;
		logic tcxo_loss;
		logic tcxo_valid;
	} cqm_state_s;

	// slew comparator result for the chosen edge or edges
	function automatic logic cqm_slew_ok(input logic rise_ok, input logic fall_ok, input logic [1:0] sel);
		if (sel == EDGE_RISE)
			return rise_ok;
		else if (sel == EDGE_FALL)
			return fall_ok;
		else
			return rise_ok & fall_ok;
	endfunction

	// swing comparator for the chosen threshold, top code doubles the highest
	function automatic logic cqm_swing_ok(input logic [2:0] ok, input logic [1:0] sel);
		if (sel == THR_LOW)
			return ok[0];
		else if (sel == THR_MID)
			return ok[1];
		else
			return ok[2];
	endfunction

endpackage
`default_nettype wire

/* logic/cqm_monitor.sv */
// clock input qualification monitor with its ahb-lite register slave
//
// Notes on behaviour
// - xo swing below chosen threshold sets loss
// - xo frequency outside range sets fault
// - xo bypass makes xo always valid
// - xo loss pin ORs amplitude and frequency
// - tcxo slew on chosen edge clears loss
// - tcxo frequency outside range sets fault
// - tcxo bypassable; loss pin ORs both flags
// - each reference qualified after clean validation time
// - per-input enables; disabled detector never flags
// - pins show all refs; status flags selected only
// - differential swing below threshold sets amplitude fault
// - cmos slew on chosen edge clears fault
// - late flag when no pulse by nominal+margin
// - late and early share window, ORed flag
// - early flag when pulse before nominal-margin
// - ppm measured against selectable zero-ppm clock
// - valid and invalid thresholds give hysteresis
// - averaging lengthens gate, shrinks ppm span
//
// Added by the designer: the register addresses and the AHB-Lite interface to the registers.
`timescale 1ns/1ns
`default_nettype none
module cqm_monitor (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	input wire logic [2:0] xo_swing_ok,
	input wire logic xo_freq_ok,
	input wire logic tcxo_slew_rise_ok,
	input wire logic tcxo_slew_fall_ok,
	input wire logic tcxo_freq_ok,
	input wire logic xo_ppm_tick,
	input wire logic tcxo_ppm_tick,
	input wire logic [3:0] ref_clk,
	input wire logic [3:0][2:0] ref_swing_ok,
	input wire logic [3:0] ref_slew_rise_ok,
	input wire logic [3:0] ref_slew_fall_ok,
	output logic xo_loss_pin,
	output logic tcxo_loss_pin,
	output logic xo_valid,
	output logic tcxo_valid,
	output logic [3:0] ref_amp_pin,
	output logic [3:0] ref_ppm_pin,
	output logic [3:0] ref_win_pin,
	output logic [3:0] ref_qualified
);

	cqm_pkg::cqm_state_s s_reg;
	cqm_pkg::cqm_state_s s_next;

	always_comb begin
		logic accept;
		logic mapped;
		logic [3:0] ref_field;
		logic [1:0] ri;
		logic [1:0] wi;
		logic zp_tick;
		logic edge_seen;
		logic amp_ok;
		logic [16:0] late_limit;
		logic [23:0] gate_len;
		logic [23:0] expect_cnt;
		logic [23:0] err;
		logic any_flag;
		cqm_pkg::cqm_status_s status;
		accept = 1'b0;
		mapped = 1'b0;
		ref_field = 4'h0;
		ri = 2'h0;
		wi = 2'h0;
		zp_tick = 1'b0;
		edge_seen = 1'b0;
		amp_ok = 1'b0;
		late_limit = 17'h00000;
		gate_len = 24'h000000;
		expect_cnt = 24'h000000;
		err = 24'h000000;
		any_flag = 1'b0;
		status = '0;
		s_next = s_reg;
		s_next.hreadyout = 1'b1;
		s_next.hresp = 1'b0;

		// data phase of a write: zero wait states, unmapped writes were dropped at the address phase
		if (s_reg.dp_write) begin
			ref_field = s_reg.dp_addr[7:4] - cqm_pkg::REF_FIRST;
			wi = ref_field[1:0];
			if (s_reg.dp_addr == cqm_pkg::OFF_CTRL) begin
				s_next.ctrl = cqm_pkg::cqm_ctrl_s'(hwdata);
				s_next.ctrl.rsvd = '0;
			end else if (s_reg.dp_addr[3:2] == cqm_pkg::REG_CFG) begin
				s_next.cfg[wi] = cqm_pkg::cqm_ref_cfg_s'(hwdata);
				s_next.cfg[wi].rsvd = '0;
			end else if (s_reg.dp_addr[3:2] == cqm_pkg::REG_WIN) begin
				s_next.win[wi] = cqm_pkg::cqm_win_cfg_s'(hwdata);
			end else if (s_reg.dp_addr[3:2] == cqm_pkg::REG_PPM) begin
				s_next.ppm[wi] = cqm_pkg::cqm_ppm_cfg_s'(hwdata);
			end else begin
				s_next.val[wi] = cqm_pkg::cqm_val_cfg_s'(hwdata);
				s_next.val[wi].rsvd = '0;
			end
		end

		// crystal input monitors; bypass forces both flags clear
		s_next.xo_amp_flag = ~s_reg.ctrl.xo_bypass &
			~cqm_pkg::cqm_swing_ok(xo_swing_ok, s_reg.ctrl.xo_thr_sel);
		s_next.xo_freq_flag = ~s_reg.ctrl.xo_bypass & ~xo_freq_ok;
		s_next.xo_loss = s_next.xo_amp_flag | s_next.xo_freq_flag;
		s_next.xo_valid = ~s_next.xo_loss;

		// compensated oscillator monitors
		s_next.tcxo_amp_flag = ~s_reg.ctrl.tcxo_bypass &
			~cqm_pkg::cqm_slew_ok(tcxo_slew_rise_ok, tcxo_slew_fall_ok, s_reg.ctrl.tcxo_edge_sel);
		s_next.tcxo_freq_flag = ~s_reg.ctrl.tcxo_bypass & ~tcxo_freq_ok;
		s_next.tcxo_loss = s_next.tcxo_amp_flag | s_next.tcxo_freq_flag;
		s_next.tcxo_valid = ~s_next.tcxo_loss;

		// the ppm gate is timed by whichever oscillator software picked
		zp_tick = s_reg.ctrl.ppm_src_tcxo ? tcxo_ppm_tick : xo_ppm_tick;

		for (int i = 0; i < cqm_pkg::NREF; i++) begin
			// ref pins are treated as synchronous levels; rising edge taken from last sample
			edge_seen = ref_clk[i] & ~s_reg.st[i].clk_prev;
			s_next.st[i].clk_prev = ref_clk[i];

			// amplitude: swing comparator in differential mode, slew comparator in cmos mode
			if (s_reg.cfg[i].diff_mode)
				amp_ok = cqm_pkg::cqm_swing_ok(ref_swing_ok[i], s_reg.cfg[i].amp_thr);
			else
				amp_ok = cqm_pkg::cqm_slew_ok(ref_slew_rise_ok[i], ref_slew_fall_ok[i],
					s_reg.cfg[i].edge_sel);
			s_next.st[i].amp_flag = s_reg.cfg[i].amp_en & ~amp_ok;

			// window detector: win_cnt is the period seen so far, in hclk cycles
			late_limit = 17'(s_reg.win[i].nominal) + 17'(s_reg.win[i].late_margin);
			if (edge_seen) begin
				s_next.st[i].win_cnt = 17'h00001;
				s_next.st[i].late_flag = 1'b0;
				s_next.st[i].early_flag = s_reg.cfg[i].early_en &
					((18'(s_reg.st[i].win_cnt) + 18'(s_reg.win[i].early_margin)) < 18'(s_reg.win[i].nominal));
			end else begin
				if (s_reg.st[i].win_cnt != '1)
					s_next.st[i].win_cnt = s_reg.st[i].win_cnt + 17'h00001;
				// limit reached with no edge: the period is already too long, flag without waiting
				if (s_reg.st[i].win_cnt >= late_limit)
					s_next.st[i].late_flag = 1'b1;
			end
			if (!s_reg.cfg[i].late_en)
				s_next.st[i].late_flag = 1'b0;
			if (!s_reg.cfg[i].early_en)
				s_next.st[i].early_flag = 1'b0;
			s_next.st[i].win_flag = s_next.st[i].late_flag | s_next.st[i].early_flag;

			// ppm monitor: count edges over a gate of zero-ppm ticks, gate grows with averaging
			gate_len = cqm_pkg::GATE_TICKS << s_reg.cfg[i].avg;
			expect_cnt = 24'(s_reg.ppm[i].expected) << s_reg.cfg[i].avg;
			if (!s_reg.cfg[i].ppm_en) begin
				s_next.st[i].ppm_flag = 1'b0;
				s_next.st[i].gate_cnt = '0;
				s_next.st[i].edge_cnt = '0;
			end else begin
				if (edge_seen)
					s_next.st[i].edge_cnt = s_reg.st[i].edge_cnt + 24'h000001;
				if (zp_tick) begin
					if (s_reg.st[i].gate_cnt >= gate_len - 24'h000001) begin
						err = (s_next.st[i].edge_cnt > expect_cnt) ? s_next.st[i].edge_cnt - expect_cnt
							: expect_cnt - s_next.st[i].edge_cnt;
						// between the two thresholds the flag holds: hysteresis
						if (err < 24'(s_reg.ppm[i].valid_thr))
							s_next.st[i].ppm_flag = 1'b0;
						else if (err > 24'(s_reg.ppm[i].invalid_thr))
							s_next.st[i].ppm_flag = 1'b1;
						s_next.st[i].gate_cnt = '0;
						s_next.st[i].edge_cnt = '0;
					end else begin
						s_next.st[i].gate_cnt = s_reg.st[i].gate_cnt + 24'h000001;
					end
				end
			end

			// validation timer over all enabled detectors of this input
			any_flag = s_next.st[i].amp_flag | s_next.st[i].ppm_flag | s_next.st[i].win_flag;
			if (any_flag) begin
				s_next.st[i].val_cnt = '0;
				s_next.st[i].qualified = 1'b0;
			end else if (!s_reg.cfg[i].val_en) begin
				s_next.st[i].val_cnt = '0;
				s_next.st[i].qualified = 1'b1;
			end else if (s_reg.st[i].val_cnt >= s_reg.val[i].val_time) begin
				s_next.st[i].qualified = 1'b1;
			end else begin
				s_next.st[i].val_cnt = s_reg.st[i].val_cnt + 20'h00001;
				s_next.st[i].qualified = 1'b0;
			end
		end

		// status word shows detector flags only for the input each loop has selected
		status.xo_amp = s_reg.xo_amp_flag;
		status.xo_freq = s_reg.xo_freq_flag;
		status.tcxo_amp = s_reg.tcxo_amp_flag;
		status.tcxo_freq = s_reg.tcxo_freq_flag;
		status.xo_valid = s_reg.xo_valid;
		status.tcxo_valid = s_reg.tcxo_valid;
		for (int i = 0; i < cqm_pkg::NREF; i++)
			status.qualified[i] = s_reg.st[i].qualified;
		status.loop0.amp = s_reg.st[s_reg.ctrl.loop0_sel].amp_flag;
		status.loop0.ppm = s_reg.st[s_reg.ctrl.loop0_sel].ppm_flag;
		status.loop0.win = s_reg.st[s_reg.ctrl.loop0_sel].win_flag;
		status.loop1.amp = s_reg.st[s_reg.ctrl.loop1_sel].amp_flag;
		status.loop1.ppm = s_reg.st[s_reg.ctrl.loop1_sel].ppm_flag;
		status.loop1.win = s_reg.st[s_reg.ctrl.loop1_sel].win_flag;

		// address phase: decode, answer reads now so data stands in the data phase
		accept = hsel & htrans[1] & hready;
		ref_field = haddr[7:4] - cqm_pkg::REF_FIRST;
		ri = ref_field[1:0];
		mapped = (haddr[31:8] == cqm_pkg::ADDR_HIGH_ZERO) & (haddr[1:0] == cqm_pkg::ADDR_ALIGNED) &
			((haddr[7:0] == cqm_pkg::OFF_CTRL) | (haddr[7:0] == cqm_pkg::OFF_STATUS) |
			((haddr[7:4] >= cqm_pkg::REF_FIRST) & (haddr[7:4] <= cqm_pkg::REF_LAST)));
		// status is read-only; a write there must not fall through into the ref decode
		s_next.dp_write = accept & hwrite & mapped & (haddr[7:0] != cqm_pkg::OFF_STATUS);
		s_next.dp_addr = haddr[7:0];
		if (accept && !hwrite) begin
			// reads see state before any write in the same cycle's data phase
			if (!mapped)
				s_next.hrdata = '0;
			else if (haddr[7:0] == cqm_pkg::OFF_CTRL)
				s_next.hrdata = s_reg.ctrl;
			else if (haddr[7:0] == cqm_pkg::OFF_STATUS)
				s_next.hrdata = status;
			else if (haddr[3:2] == cqm_pkg::REG_CFG)
				s_next.hrdata = s_reg.cfg[ri];
			else if (haddr[3:2] == cqm_pkg::REG_WIN)
				s_next.hrdata = s_reg.win[ri];
			else if (haddr[3:2] == cqm_pkg::REG_PPM)
				s_next.hrdata = s_reg.ppm[ri];
			else
				s_next.hrdata = s_reg.val[ri];
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			s_reg <= '0;
			s_reg.hreadyout <= 1'b1;
		end else begin
			s_reg <= s_next;
		end
	end

	assign hrdata = s_reg.hrdata;
	assign hreadyout = s_reg.hreadyout;
	assign hresp = s_reg.hresp;
	assign xo_loss_pin = s_reg.xo_loss;
	assign tcxo_loss_pin = s_reg.tcxo_loss;
	assign xo_valid = s_reg.xo_valid;
	assign tcxo_valid = s_reg.tcxo_valid;

	genvar g;
	generate
		for (g = 0; g < cqm_pkg::NREF; g++) begin : g_pins
			assign ref_amp_pin[g] = s_reg.st[g].amp_flag;
			assign ref_ppm_pin[g] = s_reg.st[g].ppm_flag;
			assign ref_win_pin[g] = s_reg.st[g].win_flag;
			assign ref_qualified[g] = s_reg.st[g].qualified;
		end
	endgenerate

	// checks on input 0; the other inputs share the same loop body
	logic r0_edge;
	logic [16:0] r0_late_limit;
	assign r0_edge = ref_clk[0] & ~s_reg.st[0].clk_prev;
	assign r0_late_limit = 17'(s_reg.win[0].nominal) + 17'(s_reg.win[0].late_margin);

	default clocking cb @(posedge hclk);
	endclocking
	default disable iff (!hresetn);

	xo_amp_a: assert property (
		!s_reg.ctrl.xo_bypass && s_reg.ctrl.xo_thr_sel == cqm_pkg::THR_LOW && !xo_swing_ok[0]
		|=> xo_loss_pin && !xo_valid)
		else $error("xo swing below threshold did not raise loss");

	xo_freq_a: assert property (
		!s_reg.ctrl.xo_bypass && !xo_freq_ok |=> s_reg.xo_freq_flag && xo_loss_pin)
		else $error("xo frequency fault not raised");

	xo_bypass_a: assert property (
		s_reg.ctrl.xo_bypass[*2] |-> xo_valid && !xo_loss_pin)
		else $error("bypassed xo not valid");

	xo_loss_or_a: assert property (
		xo_loss_pin == (s_reg.xo_amp_flag || s_reg.xo_freq_flag))
		else $error("xo loss pin is not the or of its flags");

	tcxo_slew_a: assert property (
		!s_reg.ctrl.tcxo_bypass && s_reg.ctrl.tcxo_edge_sel == cqm_pkg::EDGE_FALL && tcxo_slew_fall_ok
		&& tcxo_freq_ok |=> !tcxo_loss_pin && tcxo_valid)
		else $error("tcxo good falling slew did not clear loss");

	tcxo_bypass_a: assert property (
		s_reg.ctrl.tcxo_bypass |=> tcxo_valid && !s_reg.tcxo_amp_flag && !s_reg.tcxo_freq_flag)
		else $error("bypassed tcxo flagged");

	tcxo_freq_a: assert property (
		!s_reg.ctrl.tcxo_bypass && !tcxo_freq_ok |=> s_reg.tcxo_freq_flag && tcxo_loss_pin)
		else $error("tcxo frequency fault not raised");

	tcxo_loss_or_a: assert property (
		tcxo_loss_pin == (s_reg.tcxo_amp_flag || s_reg.tcxo_freq_flag))
		else $error("tcxo loss pin is not the or of its flags");

	amp_off_a: assert property (
		!s_reg.cfg[0].amp_en |=> !ref_amp_pin[0])
		else $error("disabled amplitude detector flagged");

	// swing and slew checks on input 3, the one whose comparators get swept
	diff_swing_a: assert property (
		s_reg.cfg[3].amp_en && s_reg.cfg[3].diff_mode && s_reg.cfg[3].amp_thr == cqm_pkg::THR_LOW
		&& !ref_swing_ok[3][0] |=> ref_amp_pin[3])
		else $error("low differential swing not flagged");

	cmos_slew_a: assert property (
		s_reg.cfg[3].amp_en && !s_reg.cfg[3].diff_mode && s_reg.cfg[3].edge_sel == cqm_pkg::EDGE_FALL
		&& !ref_slew_fall_ok[3] |=> ref_amp_pin[3])
		else $error("slow falling slew not flagged");

	late_flag_a: assert property (
		s_reg.cfg[0].late_en && !r0_edge && s_reg.st[0].win_cnt >= r0_late_limit |=> ref_win_pin[0])
		else $error("missing pulse not flagged at once");

	late_clear_a: assert property (
		s_reg.cfg[0].late_en && r0_edge |=> !s_reg.st[0].late_flag)
		else $error("late flag not cleared by a pulse");

	early_flag_a: assert property (
		s_reg.cfg[0].early_en && r0_edge
		&& (18'(s_reg.st[0].win_cnt) + 18'(s_reg.win[0].early_margin)) < 18'(s_reg.win[0].nominal)
		|=> ref_win_pin[0] ##1 (ref_win_pin[0] || r0_edge || !s_reg.cfg[0].early_en))
		else $error("early pulse not flagged");

	qual_drop_a: assert property (
		(ref_amp_pin[0] || ref_ppm_pin[0] || ref_win_pin[0]) |-> !ref_qualified[0] && s_reg.st[0].val_cnt == '0)
		else $error("input qualified while flagged");

	qual_timer_a: assert property (
		$rose(ref_qualified[0]) && $past(s_reg.cfg[0].val_en)
		|-> $past(s_reg.st[0].val_cnt) >= $past(s_reg.val[0].val_time))
		else $error("input qualified before validation time");

	loop_status_a: assert property (
		s_reg.ctrl.loop1_sel == 2'h2 && hsel && htrans[1] && hready && !hwrite
		&& haddr == {cqm_pkg::ADDR_HIGH_ZERO, cqm_pkg::OFF_STATUS} |=> hrdata[14] == $past(ref_ppm_pin[2]))
		else $error("status does not follow loop selection");

	xo_rise_c: cover property (!xo_valid ##1 xo_valid);
	ref_qual_c: cover property (!ref_qualified[0] ##1 ref_qualified[0]);
	early_c: cover property (s_reg.st[0].early_flag);
	ppm_c: cover property ($rose(ref_ppm_pin[0]));
	late_c: cover property (s_reg.st[0].late_flag);

endmodule
`default_nettype wire

/* verif/cqm_src.sv */
// behavioural oscillators and reference clock sources facing the monitor
`timescale 1ns/1ns
`default_nettype none
module cqm_src (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic [3:0] run,
	input wire logic [3:0][7:0] per,
	output logic [3:0] ref_clk,
	output logic xo_ppm_tick,
	output logic tcxo_ppm_tick
);
	logic [3:0][7:0] cnt_reg;
	logic [1:0] tick_reg;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cnt_reg <= '0;
			tick_reg <= 2'h0;
			ref_clk <= 4'h0;
			xo_ppm_tick <= 1'b0;
			tcxo_ppm_tick <= 1'b0;
		end else begin
			// two zero-ppm sources of different rate, so the source choice shows
			tick_reg <= tick_reg + 2'h1;
			xo_ppm_tick <= tick_reg[0];
			tcxo_ppm_tick <= tick_reg == 2'h3;
			for (int n = 0; n < 4; n++) begin
				// a stopped source holds low, a dead clock does not keep toggling
				if (!run[n] || cnt_reg[n] >= per[n] - 8'h01)
					cnt_reg[n] <= 8'h00;
				else
					cnt_reg[n] <= cnt_reg[n] + 8'h01;
				ref_clk[n] <= run[n] && cnt_reg[n] < (per[n] >> 1);
			end
		end
	end
endmodule
`default_nettype wire

/* verif/testbench.sv */
// self-checking bench for the clock input qualification monitor
`timescale 1ns/1ns
`default_nettype none
module testbench;
	logic hclk, hresetn, hsel, hwrite, hreadyout, hresp;
	logic [31:0] haddr, hwdata, hrdata, rd;
	logic [1:0] htrans;
	logic [2:0] xo_sw;
	logic xo_f, tc_r, tc_f, tc_q, xt, tt, xl, tl, xv, tv;
	logic [3:0][2:0] rsw;
	logic [3:0] rr, rf, run, rclk, amp_p, ppm_p, win_p, qual, wh;
	logic [3:0][7:0] per;
	int bad_count, n_tests;
	typedef struct packed {
		logic [10:0] ctrl;
		logic [2:0] sw;
		logic xf, r, f, tf;
		logic [3:0] e;
	} cqm_row_s;
	// e is {xo loss, tcxo loss, xo valid, tcxo valid}
	cqm_row_s rows [9] = '{
		'{11'h000, 3'h1, 1'b1, 1'b1, 1'b0, 1'b1, 4'h3},
		'{11'h004, 3'h1, 1'b1, 1'b1, 1'b0, 1'b1, 4'h9},
		'{11'h004, 3'h3, 1'b0, 1'b1, 1'b0, 1'b1, 4'h9},
		'{11'h018, 3'h3, 1'b1, 1'b1, 1'b0, 1'b1, 4'hc},
		'{11'h02c, 3'h4, 1'b1, 1'b1, 1'b1, 1'b1, 4'h3},
		'{11'h030, 3'h7, 1'b1, 1'b1, 1'b0, 1'b1, 4'h6},
		'{11'h010, 3'h7, 1'b1, 1'b0, 1'b1, 1'b0, 4'h6},
		'{11'h010, 3'h7, 1'b1, 1'b0, 1'b1, 1'b1, 4'h3},
		'{11'h003, 3'h0, 1'b0, 1'b0, 1'b0, 1'b0, 4'h3}};

	cqm_src src (.hclk(hclk), .hresetn(hresetn), .run(run), .per(per), .ref_clk(rclk),
		.xo_ppm_tick(xt), .tcxo_ppm_tick(tt));
	cqm_monitor dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp), .xo_swing_ok(xo_sw), .xo_freq_ok(xo_f),
		.tcxo_slew_rise_ok(tc_r), .tcxo_slew_fall_ok(tc_f), .tcxo_freq_ok(tc_q), .xo_ppm_tick(xt),
		.tcxo_ppm_tick(tt), .ref_clk(rclk), .ref_swing_ok(rsw), .ref_slew_rise_ok(rr),
		.ref_slew_fall_ok(rf), .xo_loss_pin(xl), .tcxo_loss_pin(tl), .xo_valid(xv), .tcxo_valid(tv),
		.ref_amp_pin(amp_p), .ref_ppm_pin(ppm_p), .ref_win_pin(win_p), .ref_qualified(qual));

	task end_of_test();
		$display("comparisons %0d mismatches %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	task chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			bad_count++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// single ahb-lite transfer, read data left in rd
	task ahb(input logic w, input logic [31:0] a, input logic [31:0] d);
		@(posedge hclk);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= a;
		hwrite <= w;
		@(posedge hclk);
		while (hreadyout !== 1'b1) @(posedge hclk);
		htrans <= 2'h0;
		hsel <= 1'b0;
		hwdata <= d;
		@(posedge hclk);
		while (hreadyout !== 1'b1) @(posedge hclk);
		rd = hrdata;
	endtask

	function automatic logic [31:0] ra(input int n, input logic [1:0] r);
		return 32'(16 * (n + 1) + 4 * r);
	endfunction

	task wt(input int n);
		repeat (n) @(posedge hclk);
	endtask

	// or of the window pins over n cycles: a late flag stands only until the next pulse
	task watch(input int n, output logic [3:0] hit);
		hit = 4'h0;
		repeat (n) begin
			@(posedge hclk);
			hit = hit | win_p;
		end
	endtask

	// ref2 runs at 4 cycles a period; wait two full gates of the new setting
	task pp(input logic [15:0] e, input logic [10:0] c, input logic [2:0] av, input logic f);
		int g;
		g = 2048 << (av + c[6]);
		ahb(1'b1, 32'(cqm_pkg::OFF_CTRL), 32'(c));
		ahb(1'b1, ra(2, cqm_pkg::REG_PPM), {e, 16'h0810});
		ahb(1'b1, ra(2, cqm_pkg::REG_CFG), 32'h8 | (32'(av) << 10));
		wt(2 * g + 100);
		chk(32'(ppm_p[2]), 32'(f));
		ahb(1'b0, 32'(cqm_pkg::OFF_STATUS), 32'h0);
		chk(32'(rd[14]), 32'(f));
	endtask

	initial begin
		hclk = 1'b0;
		forever #50 hclk = ~hclk;
	end

	initial begin
		wt(100000);
		bad_count++;
		end_of_test();
	end

	initial begin
		{hresetn, hsel, hwrite, htrans, haddr, hwdata} = '0;
		{xo_sw, xo_f, tc_r, tc_f, tc_q} = 7'h7f;
		rsw = {4{3'h7}};
		{rr, rf} = 8'hff;
		run = 4'h5;
		per = {8'h04, 8'h04, 8'h04, 8'h14};
		wt(16);
		chk(32'({hreadyout, hresp, qual}), 32'h20);
		hresetn <= 1'b1;
		wt(2);
		chk(32'(qual), 32'hf);
		foreach (rows[i]) begin
			xo_sw <= rows[i].sw;
			xo_f <= rows[i].xf;
			tc_r <= rows[i].r;
			tc_f <= rows[i].f;
			tc_q <= rows[i].tf;
			ahb(1'b1, 32'(cqm_pkg::OFF_CTRL), 32'(rows[i].ctrl));
			wt(3);
			chk(32'({xl, tl, xv, tv}), 32'(rows[i].e));
			ahb(1'b0, 32'(cqm_pkg::OFF_CTRL), 32'h0);
			chk(rd, 32'(rows[i].ctrl));
			ahb(1'b0, 32'(cqm_pkg::OFF_STATUS), 32'h0);
			chk(32'(rd[5:4]), 32'({rows[i].e[0], rows[i].e[1]}));
		end
		{xo_sw, xo_f, tc_r, tc_f, tc_q} <= 7'h7f;
		ahb(1'b1, 32'h100, 32'hffffffff);
		ahb(1'b0, 32'h100, 32'h0);
		chk(rd, 32'h0);
		ahb(1'b0, 32'h2, 32'h0);
		chk(rd, 32'h0);
		chk(32'(hresp), 32'h0);
		ahb(1'b1, 32'(cqm_pkg::OFF_STATUS), 32'hffffffff);
		ahb(1'b0, ra(3, cqm_pkg::REG_WIN), 32'h0);
		chk(rd, 32'h0);
		// swing codes 0 to 2, then the cmos edge code of the same value, on ref3
		for (int k = 0; k < 3; k++) begin
			rsw[3] <= (3'h1 << k) - 3'h1;
			ahb(1'b1, ra(3, cqm_pkg::REG_CFG), 32'h21 | 32'(k << 6));
			wt(3);
			chk(32'(amp_p[3]), 32'h1);
			rsw[3] <= 3'h1 << k;
			wt(3);
			chk(32'(amp_p[3]), 32'h0);
			rf[3] <= 1'b0;
			ahb(1'b1, ra(3, cqm_pkg::REG_CFG), 32'h1 | 32'(k << 8));
			wt(3);
			chk(32'(amp_p[3]), 32'(k != 0));
		end
		// cmos input with slow falling slew: amplitude check switched off, fault stays hidden
		ahb(1'b1, ra(3, cqm_pkg::REG_CFG), 32'h0);
		wt(3);
		chk(32'({amp_p[3], qual[3]}), 32'h1);
		// ref0: nominal 20, late 4, early 4, validation 50 cycles
		ahb(1'b1, ra(0, cqm_pkg::REG_WIN), 32'h00140404);
		ahb(1'b1, ra(0, cqm_pkg::REG_VAL), 32'd50);
		ahb(1'b1, ra(0, cqm_pkg::REG_CFG), 32'h16);
		ahb(1'b1, 32'(cqm_pkg::OFF_CTRL), 32'h200);
		wt(100);
		chk(32'({win_p[0], qual[0]}), 32'h1);
		run[0] <= 1'b0;
		wt(30);
		chk(32'({win_p[0], qual[0]}), 32'h2);
		ahb(1'b0, 32'(cqm_pkg::OFF_STATUS), 32'h0);
		chk(32'(rd[15:12]), 32'h1);
		run[0] <= 1'b1;
		wt(30);
		chk(32'(qual[0]), 32'h0);
		wt(60);
		chk(32'(qual[0]), 32'h1);
		per[0] <= 8'd24;
		wt(20);
		watch(60, wh);
		chk(32'(wh[0]), 32'h0);
		per[0] <= 8'd25;
		wt(10);
		watch(50, wh);
		chk(32'(wh[0]), 32'h1);
		per[0] <= 8'd16;
		wt(70);
		chk(32'(win_p[0]), 32'h0);
		per[0] <= 8'd15;
		wt(40);
		chk(32'({win_p[0], qual[0]}), 32'h2);
		per[0] <= 8'd20;
		wt(60);
		chk(32'(win_p[0]), 32'h0);
		chk(32'({win_p[1], qual[1]}), 32'h1);
		pp(16'd600, 11'h400, 3'h0, 1'b1);
		pp(16'd524, 11'h400, 3'h0, 1'b1);
		pp(16'd512, 11'h400, 3'h0, 1'b0);
		pp(16'd524, 11'h400, 3'h0, 1'b0);
		pp(16'd512, 11'h440, 3'h0, 1'b1);
		pp(16'd512, 11'h400, 3'h1, 1'b0);
		// second reset in mid-run clears every register except hreadyout, which comes back high
		hresetn <= 1'b0;
		wt(2);
		chk(32'({hreadyout, qual, xv}), 32'h20);
		hresetn <= 1'b1;
		ahb(1'b0, ra(0, cqm_pkg::REG_CFG), 32'h0);
		chk(rd, 32'h0);
		ahb(1'b0, 32'(cqm_pkg::OFF_CTRL), 32'h0);
		chk({rd[31:4], qual}, 32'hf);
		end_of_test();
	end
endmodule
`default_nettype wire
